// ### ssn_pkg.sv
// ==========================================================
// shared constants, types and helpers of the narrowing unit
package ssn_pkg;

   // ==========================================================
   // vector file geometry
   localparam int VLEN = 128;
   localparam int NVREG = 32;
   localparam int VIDX_W = 5;
   localparam int WORDS = VLEN / 32;
   localparam int ADDR_W = 12;

   // ==========================================================
   // register map, byte addresses
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_CMD = 12'h004;
   localparam logic [11:0] ADDR_STAT = 12'h008;
   localparam logic [2:0] VEC_SEL = 3'h1; // window 0x200..0x3FF
   localparam int VEC_TOP_LSB = 9;
   localparam int VEC_REG_LSB = 4;
   localparam int VEC_WORD_LSB = 2;

   // ==========================================================
   // control and status bits
   localparam int CTRL_FEAT_BIT = 0;
   localparam int CTRL_STRM_BIT = 1;
   localparam logic [1:0] CTRL_RST = 2'h1;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam int STAT_UNDEF_BIT = 2;
   localparam int STAT_TRAP_BIT = 3;

   // ==========================================================
   // command word fields
   localparam int OP_LSB = 0;
   localparam int SIZE_LSB = 4;
   localparam int IMM_LSB = 8;
   localparam int SRC_LSB = 16;
   localparam int DST_LSB = 24;

   // ==========================================================
   // operations
   localparam logic [2:0] OP_CVT2 = 3'h0;
   localparam logic [2:0] OP_CVT4 = 3'h1;
   localparam logic [2:0] OP_CVTN = 3'h2;
   localparam logic [2:0] OP_RSHR2 = 3'h3;
   localparam logic [2:0] OP_RSHR4 = 3'h4;
   localparam logic [1:0] TSIZE_RSVD = 2'h0;
   localparam logic [64:0] SAT8_MAX = 65'hFF;
   localparam logic [64:0] SAT16_MAX = 65'hFFFF;

   typedef struct packed {
      logic [2:0] op;
      logic [1:0] size;
      logic [4:0] imm;
      logic [4:0] src;
      logic [4:0] dst;
   } ssn_cmd_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_RD = 4'h2,
      ST_CAP = 4'h4,
      ST_WR = 4'h8
   } ssn_state_t;

   // unpack a written command word
   function automatic ssn_cmd_t ssn_word_cmd(input logic [31:0] w);
      ssn_cmd_t c;
      c.op = w[OP_LSB +: 3];
      c.size = w[SIZE_LSB +: 2];
      c.imm = w[IMM_LSB +: 5];
      c.src = w[SRC_LSB +: 5];
      c.dst = w[DST_LSB +: 5];
      return c;
   endfunction

   // legal operation and size combination
   function automatic logic ssn_op_valid(input ssn_cmd_t c);
      return (c.op <= OP_RSHR4) && !(c.op == OP_RSHR4 && c.size == TSIZE_RSVD);
   endfunction

   // add rounding constant then shift right
   function automatic logic [64:0] ssn_round_shift(input logic [63:0] x,
                                                   input logic [6:0] sh);
      logic [64:0] rc;
      rc = (sh == 7'h00) ? 65'h0 : (65'h1 << (sh - 7'h01));
      return ({1'b0, x} + rc) >> sh;
   endfunction

   function automatic logic [7:0] ssn_sat8(input logic [64:0] v);
      return (v > SAT8_MAX) ? 8'hFF : v[7:0];
   endfunction

   function automatic logic [15:0] ssn_sat16(input logic [64:0] v);
      return (v > SAT16_MAX) ? 16'hFFFF : v[15:0];
   endfunction

endpackage

// ### ssn_vreg_mem.sv
`timescale 1ns/1ps
// ==========================================================
// vector register file, word write enables, registered read
module ssn_vreg_mem (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [ssn_pkg::VIDX_W-1:0] raddr,
   output logic [ssn_pkg::VLEN-1:0] rdata,
   input wire logic [ssn_pkg::WORDS-1:0] wen,
   input wire logic [ssn_pkg::VIDX_W-1:0] waddr,
   input wire logic [ssn_pkg::VLEN-1:0] wdata
);
   import ssn_pkg::*;

   // one bank per 32-bit word, so each word has a single writing process
   for (genvar w = 0; w < WORDS; w++) begin : g_word
      logic [31:0] bank [NVREG];

      // word write, own enable
      always_ff @(posedge pclk) begin
         if (wen[w]) begin
            bank[waddr] <= wdata[w*32 +: 32];
         end
      end

      // read data lands one edge after the address
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            rdata[w*32 +: 32] <= '0;
         end else begin
            rdata[w*32 +: 32] <= bank[raddr];
         end
      end
   end
endmodule // ssn_vreg_mem

// ### ssn_narrow_unit.sv
`timescale 1ns/1ps
module ssn_narrow_unit (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ssn_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   import ssn_pkg::*;

   // ==========================================================
   // state
   ssn_state_t state_reg;
   ssn_state_t state_next;
   ssn_cmd_t cmd_reg;
   ssn_cmd_t cmd_in;
   logic [1:0] ctrl_reg;
   logic [1:0] cnt_reg;
   logic [1:0] cnt_next;
   logic [VLEN-1:0] src_reg [4];
   logic done_reg;
   logic undef_reg;
   logic trap_reg;
   logic [31:0] prdata_next;
   logic pslverr_next;

   // ==========================================================
   // apb decode
   wire logic sel_ctrl = (paddr == ADDR_CTRL);
   wire logic sel_cmd = (paddr == ADDR_CMD);
   wire logic sel_stat = (paddr == ADDR_STAT);
   wire logic sel_vec = (paddr[ADDR_W-1:VEC_TOP_LSB] == VEC_SEL);
   wire logic sel_any = sel_ctrl | sel_cmd | sel_stat | sel_vec;
   wire logic busy = (state_reg != ST_IDLE);
   wire logic access_first = psel & penable & ~pready;
   wire logic apb_done = psel & penable & pready;
   wire logic commit_wr = apb_done & pwrite & ~pslverr;
   wire logic launch = commit_wr & sel_cmd;
   wire logic vec_wr = commit_wr & sel_vec;
   wire logic [VIDX_W-1:0] bus_vidx = paddr[VEC_REG_LSB +: VIDX_W];
   wire logic [1:0] bus_word = paddr[VEC_WORD_LSB +: 2];
   wire logic feat_on = ctrl_reg[CTRL_FEAT_BIT];
   wire logic strm_on = ctrl_reg[CTRL_STRM_BIT];

   // vector window and commands are refused while an operation runs
   assign pslverr_next = ~sel_any | (busy & (sel_vec | (sel_cmd & pwrite)));

   // ==========================================================
   // command decode
   assign cmd_in = ssn_word_cmd(pwdata);
   wire logic op_two = (cmd_reg.op == OP_CVT2) | (cmd_reg.op == OP_RSHR2);
   wire logic op_rshr4 = (cmd_reg.op == OP_RSHR4);
   wire logic op_ilv = (cmd_reg.op == OP_CVTN);
   // wide selects 64-bit sources and halfword results of four-source operations
   wire logic wide = op_rshr4 ? cmd_reg.size[1] : cmd_reg.size[0];
   wire logic [1:0] last_src = op_two ? 2'h1 : 2'h3;

   // shift amounts, plain narrowing uses zero
   wire logic [6:0] sh_short = {3'h0, cmd_reg.imm[3:0]} + 7'h01;
   wire logic [6:0] sh_long = wide ? ({1'b0, cmd_reg.size[0], cmd_reg.imm} + 7'h01)
                                   : ({2'h0, cmd_reg.imm} + 7'h01);
   wire logic [6:0] shift_amt = (cmd_reg.op == OP_RSHR2) ? sh_short :
                                op_rshr4 ? sh_long : 7'h00;

   // source register numbering
   wire logic [VIDX_W-1:0] base_two = {cmd_reg.src[3:0], 1'b0};
   wire logic [VIDX_W-1:0] base_four = {cmd_reg.src[2:0], 2'h0};
   wire logic [VIDX_W-1:0] src_base = op_two ? base_two : base_four;
   wire logic [VIDX_W-1:0] eng_raddr = src_base + {3'h0, cnt_reg};

   // ==========================================================
   // vector file ports
   logic [VLEN-1:0] mem_rdata;
   logic [VLEN-1:0] result;
   wire logic eng_wr = (state_reg == ST_WR);
   wire logic [VIDX_W-1:0] mem_raddr = busy ? eng_raddr : bus_vidx;
   wire logic [VIDX_W-1:0] mem_waddr = eng_wr ? cmd_reg.dst : bus_vidx;
   wire logic [WORDS-1:0] bus_wen = vec_wr ? (WORDS'(1) << bus_word) : '0;
   wire logic [WORDS-1:0] mem_wen = eng_wr ? '1 : bus_wen;
   wire logic [VLEN-1:0] mem_wdata = eng_wr ? result : {WORDS{pwdata}};

   ssn_vreg_mem u_mem (
      .pclk(pclk),
      .presetn(presetn),
      .raddr(mem_raddr),
      .rdata(mem_rdata),
      .wen(mem_wen),
      .waddr(mem_waddr),
      .wdata(mem_wdata)
   );

   // ==========================================================
   // element datapath, every lane always active
   logic [7:0] n8 [4][4];
   logic [15:0] n16a [4][4];
   logic [15:0] n16b [4][2];
   logic [VLEN-1:0] lay_a;
   logic [VLEN-1:0] lay_b;
   logic [VLEN-1:0] lay_c;
   logic [VLEN-1:0] lay_d;
   logic [VLEN-1:0] lay_e;

   // 32-bit source elements, rounded, shifted, clamped
   for (genvar r = 0; r < 4; r++) begin : g_s32
      for (genvar e = 0; e < 4; e++) begin : g_el
         logic [64:0] v;
         assign v = ssn_round_shift({32'h0, src_reg[r][e*32 +: 32]}, shift_amt);
         assign n8[r][e] = ssn_sat8(v);
         assign n16a[r][e] = ssn_sat16(v);
      end
   end

   // 64-bit source elements
   for (genvar r = 0; r < 4; r++) begin : g_s64
      for (genvar e = 0; e < 2; e++) begin : g_el
         logic [64:0] v;
         assign v = ssn_round_shift(src_reg[r][e*64 +: 64], shift_amt);
         assign n16b[r][e] = ssn_sat16(v);
      end
   end

   // halfword results from two sources, source order
   for (genvar r = 0; r < 2; r++) begin : g_lay_a
      for (genvar e = 0; e < 4; e++) begin : g_el
         assign lay_a[(r*4+e)*16 +: 16] = n16a[r][e];
      end
   end

   // byte results from four sources, concatenated and interleaved
   for (genvar r = 0; r < 4; r++) begin : g_lay_bd
      for (genvar e = 0; e < 4; e++) begin : g_el
         assign lay_b[(r*4+e)*8 +: 8] = n8[r][e];
         assign lay_d[(e*4+r)*8 +: 8] = n8[r][e];
      end
   end

   // halfword results from four 64-bit sources
   for (genvar r = 0; r < 4; r++) begin : g_lay_ce
      for (genvar e = 0; e < 2; e++) begin : g_el
         assign lay_c[(r*2+e)*16 +: 16] = n16b[r][e];
         assign lay_e[(e*4+r)*16 +: 16] = n16b[r][e];
      end
   end

   // destination layout by operation and width
   wire logic [VLEN-1:0] lay_quarter = wide ? lay_c : lay_b;
   wire logic [VLEN-1:0] lay_ilv = wide ? lay_e : lay_d;
   assign result = op_two ? lay_a : (op_ilv ? lay_ilv : lay_quarter);

   // ==========================================================
   // sequencer: read sources one by one, then write destination
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      case (state_reg)
         ST_IDLE: begin
            cnt_next = 2'h0;
            if (launch && feat_on && ssn_op_valid(cmd_in) && strm_on) begin
               state_next = ST_RD;
            end
         end
         ST_RD: begin
            state_next = ST_CAP;
         end
         ST_CAP: begin
            if (cnt_reg == last_src) begin
               state_next = ST_WR;
            end else begin
               state_next = ST_RD;
               cnt_next = cnt_reg + 2'h1;
            end
         end
         ST_WR: begin
            state_next = ST_IDLE;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_IDLE;
         cnt_reg <= 2'h0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   // capture source vectors as they return from the file
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 4; i++) begin
            src_reg[i] <= '0;
         end
      end else if (state_reg == ST_CAP) begin
         src_reg[cnt_reg] <= mem_rdata;
      end
   end

   // command latch and control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_reg <= '0;
         ctrl_reg <= CTRL_RST;
      end else begin
         if (launch) begin
            cmd_reg <= cmd_in;
         end
         if (commit_wr && sel_ctrl) begin
            ctrl_reg <= pwdata[1:0];
         end
      end
   end

   // ==========================================================
   // outcome flags, reloaded by each launch: done cleared, undefined and trap set from the new command
   wire logic undef_hit = ~feat_on | ~ssn_op_valid(cmd_in);
   wire logic trap_hit = ~undef_hit & ~strm_on;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_reg <= 1'b0;
         undef_reg <= 1'b0;
         trap_reg <= 1'b0;
      end else begin
         if (launch) begin
            undef_reg <= undef_hit;
            trap_reg <= trap_hit;
            done_reg <= 1'b0;
         end else if (eng_wr) begin
            done_reg <= 1'b1;
         end
      end
   end

   // ==========================================================
   // apb answer, one wait state on every access
   wire logic [31:0] stat_word = ({31'h0, busy} << STAT_BUSY_BIT)
                               | ({31'h0, done_reg} << STAT_DONE_BIT)
                               | ({31'h0, undef_reg} << STAT_UNDEF_BIT)
                               | ({31'h0, trap_reg} << STAT_TRAP_BIT);
   wire logic [31:0] cmd_word = ({29'h0, cmd_reg.op} << OP_LSB)
                              | ({30'h0, cmd_reg.size} << SIZE_LSB)
                              | ({27'h0, cmd_reg.imm} << IMM_LSB)
                              | ({27'h0, cmd_reg.src} << SRC_LSB)
                              | ({27'h0, cmd_reg.dst} << DST_LSB);
   wire logic [31:0] vec_word = mem_rdata[bus_word*32 +: 32];

   // read data mux, zero on error or write
   always_comb begin
      prdata_next = 32'h0;
      if (!pwrite && !pslverr_next) begin
         if (sel_ctrl) begin
            prdata_next = {30'h0, ctrl_reg};
         end else if (sel_cmd) begin
            prdata_next = cmd_word;
         end else if (sel_stat) begin
            prdata_next = stat_word;
         end else begin
            prdata_next = vec_word;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= access_first;
         if (access_first) begin
            pslverr <= pslverr_next;
            prdata <= prdata_next;
         end else if (apb_done) begin
            pslverr <= 1'b0;
            prdata <= 32'h0;
         end
      end
   end
endmodule // ssn_narrow_unit

// ### ssn_narrow_props.sv
`timescale 1ns/1ps
// ==========================================================
// bus timing checks of the narrowing unit
module ssn_narrow_props
   import ssn_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ssn_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // transfer phases
   sequence setup_s; psel && !penable; endsequence
   sequence access_s; psel && penable; endsequence
   // decoded places on the bus
   wire mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_CMD) || (paddr == ADDR_STAT)
      || (paddr[11:VEC_TOP_LSB] == VEC_SEL);
   wait_state_a: assert property (setup_s ##1 access_s |-> !pready ##1 pready)
      else $error("ready not on second access cycle");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   ready_access_a: assert property (pready |-> access_s ##0 $past(psel && penable))
      else $error("ready outside an access phase");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   idle_rdata_a: assert property (!pready |-> prdata == 32'h0)
      else $error("read data not zero while idle");
   write_rdata_a: assert property (pready && pwrite |-> prdata == 32'h0)
      else $error("read data not zero on a write");
   unmapped_err_a: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   ctrl_ok_a: assert property (pready && paddr == ADDR_CTRL |-> !pslverr)
      else $error("control access refused");
   stat_write_a: assert property (pready && pwrite && paddr == ADDR_STAT |-> !pslverr)
      else $error("status write flagged as error");
endmodule // ssn_narrow_props
bind ssn_narrow_unit ssn_narrow_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr));

// ### ssn_apb_master.sv
`timescale 1ns/1ps
// ==========================================================
// bus master standing in for the host side
module ssn_apb_master (
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [ssn_pkg::ADDR_W-1:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   import ssn_pkg::*;
   // idle bus at time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = 32'h0;
   end
   // one transfer, held until ready is seen at an edge or 20 edges have passed
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e, output logic ok);
      ok = 1'b0;
      r = 32'h0;
      e = 1'b0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (int i = 0; i < 20 && !ok; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) begin
            ok = 1'b1;
            r = prdata;
            e = pslverr;
         end
      end
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d; // stale data not left on the bus
   endtask
endmodule // ssn_apb_master

// ### tb_saturating_narrow_unit.sv
`timescale 1ns/1ps
// ==========================================================
// self-checking bench of the narrowing unit
module tb_saturating_narrow_unit;
   import ssn_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, r, st;
   logic [127:0] vr [4];
   logic [31:0] pat [4];
   int fails, samples_checked;
   int t_op [11] = '{0, 1, 1, 2, 2, 3, 3, 4, 4, 4, 4};
   int t_sz [11] = '{0, 0, 1, 0, 1, 0, 0, 1, 1, 2, 3};
   int t_im [11] = '{0, 0, 0, 0, 0, 0, 15, 0, 31, 0, 31};
   int t_sh [11] = '{0, 0, 0, 0, 0, 1, 16, 1, 32, 1, 64};

   ssn_narrow_unit DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   ssn_apb_master m (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   // clock
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   task automatic conclude();
      $display("counts: fails=%0d samples_checked=%0d", fails, samples_checked);
      if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // one bus access, a lost answer ends the run
   task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d);
      logic ok;
      m.xfer(wr, a, d, r, e, ok);
      if (!ok) begin
         fails++;
         $display("mismatch at %0t: no ready answer", $time);
         conclude();
      end
   endtask

   function automatic logic [11:0] va(input int n, input int w);
      return 12'h200 + 12'(n * 16 + w * 4);
   endfunction

   // command word, destination register 8
   function automatic logic [31:0] cw(input int op, input int sz, input int im, input int src);
      return 32'((op << OP_LSB) | (sz << SIZE_LSB) | (im << IMM_LSB)
         | (src << SRC_LSB) | (8 << DST_LSB));
   endfunction

   // launch a command and poll status until idle
   task automatic run(input int op, input int sz, input int im, input int src);
      acc(1'b1, ADDR_CMD, cw(op, sz, im, src));
      settle();
   endtask

   // poll status until the engine is idle
   task automatic settle();
      st = 32'h1;
      for (int i = 0; i < 40 && st[STAT_BUSY_BIT] !== 1'b0; i++) begin
         acc(1'b0, ADDR_STAT, 32'h0);
         st = r;
      end
      if (st[STAT_BUSY_BIT] !== 1'b0) begin
         fails++;
         $display("mismatch at %0t: engine stuck busy", $time);
         conclude();
      end
   endtask

   // expected result from the source group held in vr
   function automatic logic [127:0] ref_narrow(input int op, input int sz, input int sh);
      logic [127:0] res;
      logic [64:0] x, mx;
      int nr, dw, sw, ne, di;
      res = '0;
      nr = (op == 0 || op == 3) ? 2 : 4;
      dw = (nr == 2) ? 16 : ((op == 4) ? (sz[1] ? 16 : 8) : (sz[0] ? 16 : 8));
      sw = dw * nr;
      ne = 128 / sw;
      mx = (65'h1 << dw) - 65'h1;
      for (int q = 0; q < nr; q++) begin
         for (int k = 0; k < ne; k++) begin
            x = 65'(vr[q] >> (k * sw)) & ((65'h1 << sw) - 65'h1);
            if (sh > 0) x = (x + (65'h1 << (sh - 1))) >> sh;
            if (x > mx) x = mx;
            di = (op == 2) ? 4 * k + q : q * ne + k;
            res = res | (128'(x) << (di * dw));
         end
      end
      return res;
   endfunction

   // main sequence
   initial begin
      fails = 0;
      samples_checked = 0;
      pat = '{32'h0000_0012, 32'h0000_0000, 32'h0001_8001, 32'h0000_00FF};
      presetn = 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      acc(1'b0, ADDR_CTRL, 32'h0);
      check(r, 32'h1, "control reset");
      acc(1'b0, ADDR_STAT, 32'h0);
      check(r, 32'h0, "status reset");
      acc(1'b0, 12'h00C, 32'h0);
      check({31'h0, e}, 32'h1, "unmapped error");
      acc(1'b1, ADDR_STAT, 32'hF);
      check({31'h0, e}, 32'h0, "status write");
      // source group 4..7 and a marked destination
      for (int n = 0; n < 4; n++) begin
         for (int w = 0; w < 4; w++) begin
            vr[n][w * 32 +: 32] = pat[(n + w) % 4];
            acc(1'b1, va(4 + n, w), pat[(n + w) % 4]);
         end
      end
      // feature missing, then streaming off: nothing written
      acc(1'b1, va(8, 0), 32'hA5A5_A5A5);
      acc(1'b1, ADDR_CTRL, 32'h0);
      run(0, 0, 0, 2);
      check(st, 32'h1 << STAT_UNDEF_BIT, "undefined without feature");
      acc(1'b1, ADDR_CTRL, 32'h1);
      run(0, 0, 0, 2);
      check(st, 32'h1 << STAT_TRAP_BIT, "trap outside streaming");
      acc(1'b1, ADDR_CTRL, 32'h3);
      acc(1'b0, ADDR_CTRL, 32'h0);
      check(r, 32'h3, "control readback");
      run(4, 0, 0, 1);
      check(st, 32'h1 << STAT_UNDEF_BIT, "reserved shift size");
      run(5, 0, 0, 1);
      check(st, 32'h1 << STAT_UNDEF_BIT, "unknown operation");
      acc(1'b0, va(8, 0), 32'h0);
      check(r, 32'hA5A5_A5A5, "destination untouched");
      // vector window and a second command refused while busy
      acc(1'b1, ADDR_CMD, cw(1, 0, 0, 1));
      acc(1'b0, va(8, 0), 32'h0);
      check({31'h0, e}, 32'h1, "vector access while busy");
      acc(1'b1, ADDR_CMD, cw(2, 1, 0, 1));
      check({31'h0, e}, 32'h1, "command while busy");
      settle();
      check(st, 32'h1 << STAT_DONE_BIT, "done after refused command");
      acc(1'b0, ADDR_CMD, 32'h0);
      check(r, cw(1, 0, 0, 1), "command readback");
      // every operation and shift boundary
      for (int t = 0; t < 11; t++) begin
         for (int w = 0; w < 4; w++) acc(1'b1, va(8, w), 32'hA5A5_A5A5);
         run(t_op[t], t_sz[t], t_im[t], (t_op[t] == 0 || t_op[t] == 3) ? 2 : 1);
         check(st, 32'h1 << STAT_DONE_BIT, "done status");
         for (int w = 0; w < 4; w++) begin
            acc(1'b0, va(8, w), 32'h0);
            check(r, 32'(ref_narrow(t_op[t], t_sz[t], t_sh[t]) >> (w * 32)), "result");
         end
      end
      conclude();
   end
endmodule // tb_saturating_narrow_unit
